// File: design/rmc_map.svh
// register offsets, field positions, encodings and reset values of the resource monitor
`ifndef RMC_MAP_SVH
`define RMC_MAP_SVH

// register byte offsets on the apb window
`define RMC_OFS_QSEL 12'h000
`define RMC_OFS_QEBX 12'h004
`define RMC_OFS_QECX 12'h008
`define RMC_OFS_QEDX 12'h00C
`define RMC_OFS_EVTSEL 12'h010
`define RMC_OFS_COUNTER 12'h014
`define RMC_OFS_ASSOC0 12'h020
`define RMC_ASSOC_STRIDE 12'h004

// feature query select fields
`define RMC_QSEL_LEAF_LSB 0
`define RMC_QSEL_SUB_LSB 8
`define RMC_LEAF_EXT 8'h07
`define RMC_LEAF_MON 8'h0F
`define RMC_SUB_BASE 8'h00
`define RMC_SUB_RES_L3 8'h01
`define RMC_FEAT_MON_BIT 12
`define RMC_RES_L3_BIT 1

// event select fields
`define RMC_EVT_CODE_LSB 0
`define RMC_EVT_TAG_LSB 16
`define RMC_EVT_TAG_W 10

// event codes
`define RMC_EVT_OCC 8'h01
`define RMC_EVT_TOT 8'h02
`define RMC_EVT_LOC 8'h03

// counter word flag positions
`define RMC_CTR_ERR_BIT 31
`define RMC_CTR_UNAV_BIT 30
`define RMC_CTR_OVF_BIT 29
`define RMC_CTR_DATA_W 29

// reset values
`define RMC_RST_WORD 32'h0000_0000

`endif

// File: design/rmc_pkg.sv
// types shared by the resource monitor
package rmc_pkg;

    // one cycle of traffic from a thread, already in upscaling-factor units
    typedef struct packed {
        logic fill;
        logic bw_total;
        logic bw_local;
    } rmc_traffic_t;

    // flag and data view of the counter word
    typedef struct packed {
        logic err;
        logic unav;
        logic ovf;
        logic [28:0] data;
    } rmc_ctr_word_t;

endpackage

// File: design/rmc_top.sv
// per-thread resource monitor: tag association, occupancy and bandwidth counters, apb readout
// Overview of operation
// [R1] accesses to monitor registers on unsupported platform answer with apb error
// [R2] leaf 7 subleaf 0 reports monitor support in ebx bit 12
// [R3] leaf 0xF subleaf 0 gives highest tag id in ebx, resources in edx
// [R4] resource subleaf gives highest id, event mask and upscaling factor
// [R5] every thread starts associated with tag id zero
// [R6] traffic is counted against the tag currently held for each thread
// [R7] writing tag and event code selects which counter the counter register shows
// [R8] error flag for tag above global maximum or unknown or unsupported code
// [R9] unavailable flag for tags above the resource's own count
// [R10] overflow flag set whenever the selected bandwidth counter wraps
// [R11] error clears by itself once selection is valid and no hold exists
// [R12] reading the counter register clears the overflow flag
// [R13] codes 0x2 and 0x3 select total and local bandwidth
// [R14] code 0x1 selects cache occupancy
// [R15] software discards data whenever any flag is set
// [R16] bandwidth counters run freely, reads never reset them
// [R17] counters count in upscaling-factor units
// [R18] occupancy drops on eviction even when no thread uses that tag
// [R19] software moves tags on context switch and migration
// [R20] counter register always follows latest select; data zero when error or unavailable is flagged
`timescale 1ns/1ps
`include "rmc_map.svh"
module rmc_top import rmc_pkg::*; #(
    parameter int NUM_THREADS = 4,
    parameter int NUM_IDS = 16,
    parameter int RES_IDS = 8,
    parameter int CTR_W = 24,
    parameter bit MON_SUP = 1'b1,
    parameter bit OCC_SUP = 1'b1,
    parameter bit BW_SUP = 1'b1,
    parameter bit OVF_SUP = 1'b1,
    parameter logic [31:0] UPSCALE = 32'h0000_E000,
    parameter int ID_W = $clog2(NUM_IDS)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rmc_traffic_t [NUM_THREADS-1:0] thread_traffic,
    input wire logic evict_valid,
    input wire logic [ID_W-1:0] evict_tag,
    input wire logic monitor_hold,
    output logic [NUM_THREADS-1:0][ID_W-1:0] thread_tag
);
    localparam int INC_W = $clog2(NUM_THREADS + 1);
    localparam int TW = `RMC_EVT_TAG_W;

    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic [15:0] qsel_q;
    logic [TW-1:0] evt_tag_q;
    logic [7:0] evt_code_q;
    logic [NUM_THREADS-1:0][ID_W-1:0] thread_tag_q;
    logic [NUM_THREADS-1:0] assoc_wr_q;
    logic [CTR_W-1:0] occ_q [NUM_IDS];
    logic [CTR_W-1:0] tot_q [NUM_IDS];
    logic [CTR_W-1:0] loc_q [NUM_IDS];
    logic [CTR_W-1:0] occ_d [NUM_IDS];
    logic [CTR_W-1:0] tot_d [NUM_IDS];
    logic [CTR_W-1:0] loc_d [NUM_IDS];
    logic [NUM_IDS-1:0] tot_c, loc_c, ovf_tot_q, ovf_loc_q;
    logic [INC_W-1:0] occ_inc [NUM_IDS];
    logic [INC_W-1:0] tot_inc [NUM_IDS];
    logic [INC_W-1:0] loc_inc [NUM_IDS];
    logic [31:0] rd_mux, q_ebx, q_ecx, q_edx;
    logic hit, mon_reg, fault, done, wr_ok, ctr_read;
    logic code_occ, code_tot, code_loc, code_ok, id_ok;
    logic [ID_W-1:0] sel;
    rmc_ctr_word_t ctr_word;
    logic [31:0] qsel_wd, evt_wd;
    logic [31:0] assoc_wd [NUM_THREADS];

    // byte-lane merge so narrow apb4 writes touch only their lanes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    assign done = psel & penable & pready_q;
    assign wr_ok = done & pwrite & hit & ~fault;
    assign fault = mon_reg & ~MON_SUP; // R1
    assign ctr_read = done & ~pwrite & ~fault & (paddr == `RMC_OFS_COUNTER);
    assign pready = pready_q;
    assign pslverr = pready_q & pslverr_q;
    assign prdata = prdata_q;
    assign thread_tag = thread_tag_q;

    // merged write words, one per writable register, so lanes outside pstrb keep old bits
    assign qsel_wd = merge({16'h0000, qsel_q}, pwdata, pstrb);
    assign evt_wd = merge({6'h00, evt_tag_q, 8'h00, evt_code_q}, pwdata, pstrb);
    always_comb begin
        for (int t = 0; t < NUM_THREADS; t++) begin
            assoc_wd[t] = merge(32'(thread_tag_q[t]), pwdata, pstrb);
        end
    end

    // feature query answers, computed from the query select
    always_comb begin
        q_ebx = '0;
        q_ecx = '0;
        q_edx = '0;
        if (qsel_q[7:0] == `RMC_LEAF_EXT && qsel_q[15:8] == `RMC_SUB_BASE) begin
            q_ebx[`RMC_FEAT_MON_BIT] = MON_SUP; // R2
        end else if (MON_SUP && qsel_q[7:0] == `RMC_LEAF_MON) begin
            if (qsel_q[15:8] == `RMC_SUB_BASE) begin
                q_ebx = 32'(NUM_IDS - 1); // R3
                q_edx[`RMC_RES_L3_BIT] = OCC_SUP | BW_SUP; // R3
            end else if (qsel_q[15:8] == `RMC_SUB_RES_L3) begin
                q_ebx = UPSCALE; // R4 R17
                q_ecx = 32'(RES_IDS - 1); // R4
                q_edx = {29'h0000_0000, BW_SUP, BW_SUP, OCC_SUP}; // R4
            end
        end
    end

    // event decode and counter word; data zeroed when it could mislead
    always_comb begin
        code_occ = OCC_SUP && evt_code_q == `RMC_EVT_OCC; // R14
        code_tot = BW_SUP && evt_code_q == `RMC_EVT_TOT; // R13
        code_loc = BW_SUP && evt_code_q == `RMC_EVT_LOC; // R13
        code_ok = code_occ | code_tot | code_loc;
        id_ok = evt_tag_q < TW'(NUM_IDS);
        sel = evt_tag_q[ID_W-1:0];
        ctr_word = '0;
        ctr_word.err = ~code_ok | ~id_ok | monitor_hold; // R8 R11
        ctr_word.unav = id_ok & (evt_tag_q >= TW'(RES_IDS)); // R9
        if (!ctr_word.err && !ctr_word.unav) begin
            // R7 R20
            if (code_occ) begin
                ctr_word.data = 29'(occ_q[sel]);
            end else if (code_tot) begin
                ctr_word.data = 29'(tot_q[sel]);
            end else begin
                ctr_word.data = 29'(loc_q[sel]);
            end
            ctr_word.ovf = OVF_SUP & ((code_tot & ovf_tot_q[sel]) | (code_loc & ovf_loc_q[sel]));
        end
    end

    // address decode and read mux
    always_comb begin
        hit = 1'b1;
        mon_reg = 1'b1;
        rd_mux = `RMC_RST_WORD;
        unique case (paddr)
            `RMC_OFS_QSEL: begin
                mon_reg = 1'b0;
                rd_mux = {16'h0000, qsel_q};
            end
            `RMC_OFS_QEBX: begin
                mon_reg = 1'b0;
                rd_mux = q_ebx;
            end
            `RMC_OFS_QECX: begin
                mon_reg = 1'b0;
                rd_mux = q_ecx;
            end
            `RMC_OFS_QEDX: begin
                mon_reg = 1'b0;
                rd_mux = q_edx;
            end
            `RMC_OFS_EVTSEL: rd_mux = {6'h00, evt_tag_q, 8'h00, evt_code_q};
            `RMC_OFS_COUNTER: rd_mux = ctr_word;
            default: begin
                hit = 1'b0;
                mon_reg = 1'b0;
                for (int t = 0; t < NUM_THREADS; t++) begin
                    if (paddr == 12'(`RMC_OFS_ASSOC0 + `RMC_ASSOC_STRIDE * t)) begin
                        hit = 1'b1;
                        mon_reg = 1'b1;
                        rd_mux = 32'(thread_tag_q[t]);
                    end
                end
            end
        endcase
        if (fault) begin
            rd_mux = `RMC_RST_WORD;
        end
    end

    // apb answer: one wait state, data and error caught in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `RMC_RST_WORD;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= ~hit | fault; // R1
            prdata_q <= pwrite ? `RMC_RST_WORD : rd_mux;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // query select and event select, written only at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qsel_q <= '0;
            evt_tag_q <= '0;
            evt_code_q <= '0;
        end else if (wr_ok && paddr == `RMC_OFS_QSEL) begin
            qsel_q <= qsel_wd[15:0];
        end else if (wr_ok && paddr == `RMC_OFS_EVTSEL) begin
            evt_tag_q <= evt_wd[25:16]; // R7
            evt_code_q <= evt_wd[7:0]; // R7
        end
    end

    // per-thread tag association; upper tag bits beyond the id range are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thread_tag_q <= '0; // R5
            assoc_wr_q <= '0;
        end else begin
            for (int t = 0; t < NUM_THREADS; t++) begin
                if (wr_ok && paddr == 12'(`RMC_OFS_ASSOC0 + `RMC_ASSOC_STRIDE * t)) begin
                    thread_tag_q[t] <= assoc_wd[t][ID_W-1:0];
                    assoc_wr_q[t] <= 1'b1;
                end
            end
        end
    end

    // per-tag increments summed over all threads sharing a tag
    always_comb begin
        for (int i = 0; i < NUM_IDS; i++) begin
            occ_inc[i] = '0;
            tot_inc[i] = '0;
            loc_inc[i] = '0;
            for (int t = 0; t < NUM_THREADS; t++) begin
                if (thread_tag_q[t] == ID_W'(i)) begin
                    // R6
                    occ_inc[i] = occ_inc[i] + INC_W'(thread_traffic[t].fill);
                    tot_inc[i] = tot_inc[i] + INC_W'(thread_traffic[t].bw_total);
                    loc_inc[i] = loc_inc[i] + INC_W'(thread_traffic[t].bw_local);
                end
            end
        end
    end

    // next counter values; occupancy clamps, bandwidth wraps with a carry
    always_comb begin
        for (int i = 0; i < NUM_IDS; i++) begin
            logic [CTR_W:0] up;
            logic dec;
            up = {1'b0, occ_q[i]} + (CTR_W+1)'(occ_inc[i]);
            dec = evict_valid && evict_tag == ID_W'(i); // R18
            if (dec && up != '0) begin
                up = up - (CTR_W+1)'(1);
            end
            occ_d[i] = up[CTR_W] ? {CTR_W{1'b1}} : up[CTR_W-1:0];
            {tot_c[i], tot_d[i]} = {1'b0, tot_q[i]} + (CTR_W+1)'(tot_inc[i]); // R16 R17
            {loc_c[i], loc_d[i]} = {1'b0, loc_q[i]} + (CTR_W+1)'(loc_inc[i]); // R16 R17
        end
    end

    // occupancy counters follow residency, not scheduling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_IDS; i++) begin
                occ_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_IDS; i++) begin
                occ_q[i] <= occ_d[i]; // R18
            end
        end
    end

    // bandwidth counters never see the bus, so reads cannot disturb them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_IDS; i++) begin
                tot_q[i] <= '0;
                loc_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_IDS; i++) begin
                tot_q[i] <= tot_d[i]; // R16
                loc_q[i] <= loc_d[i]; // R16
            end
        end
    end

    // overflow flags: a wrap in the clearing cycle wins over the read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_tot_q <= '0;
            ovf_loc_q <= '0;
        end else begin
            for (int i = 0; i < NUM_IDS; i++) begin
                if (tot_c[i]) begin
                    ovf_tot_q[i] <= OVF_SUP; // R10
                end else if (ctr_read && code_tot && id_ok && sel == ID_W'(i)) begin
                    ovf_tot_q[i] <= 1'b0; // R12
                end
                if (loc_c[i]) begin
                    ovf_loc_q[i] <= OVF_SUP; // R10
                end else if (ctr_read && code_loc && id_ok && sel == ID_W'(i)) begin
                    ovf_loc_q[i] <= 1'b0; // R12
                end
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_fault_unsup: assert property (done && mon_reg && !MON_SUP |-> pslverr) // R1
        else $error("monitor access on unsupported platform not refused");
    a_feat_bit: assert property (qsel_q == {`RMC_SUB_BASE, `RMC_LEAF_EXT} |-> // R2
        q_ebx[`RMC_FEAT_MON_BIT] == MON_SUP)
        else $error("monitor support bit wrong");
    a_max_id: assert property (MON_SUP && qsel_q == {`RMC_SUB_BASE, `RMC_LEAF_MON} |-> // R3
        q_ebx == 32'(NUM_IDS - 1))
        else $error("highest tag id wrong");
    a_res_enum: assert property (MON_SUP && qsel_q == {`RMC_SUB_RES_L3, `RMC_LEAF_MON} |-> // R4
        q_ebx == UPSCALE && q_ecx == 32'(RES_IDS - 1))
        else $error("resource enumeration wrong");
    a_assoc_default: assert property (!assoc_wr_q[0] |-> thread_tag_q[0] == '0) // R5
        else $error("thread left tag zero without a write");
    a_fill_attrib: assert property (thread_traffic[0].fill && !evict_valid && // R6
        occ_q[thread_tag_q[0]] < {CTR_W{1'b1}} - CTR_W'(NUM_THREADS) |=>
        occ_q[$past(thread_tag_q[0])] > $past(occ_q[thread_tag_q[0]]))
        else $error("fill not counted against thread tag");
    a_err_flag: assert property (!code_ok || !id_ok |-> ctr_word.err && ctr_word.data == '0) // R8
        else $error("error flag missing for bad selection");
    a_unav_flag: assert property (id_ok && evt_tag_q >= TW'(RES_IDS) |-> ctr_word.unav) // R9
        else $error("unavailable flag missing");
    a_err_clear: assert property (code_ok && id_ok && !monitor_hold |-> !ctr_word.err) // R11
        else $error("error flag stuck on valid selection");
    a_ovf_set: assert property (OVF_SUP && tot_c[sel] |=> ovf_tot_q[$past(sel)]) // R10
        else $error("wrap of total counter not flagged");
    a_ovf_clr: assert property (ctr_read && code_tot && id_ok && !tot_c[sel] |=> // R12
        !ovf_tot_q[$past(sel)])
        else $error("overflow not cleared by counter read");
    a_bw_free: assert property (ctr_read && code_tot && id_ok && tot_inc[sel] == '0 |=> // R16
        tot_q[$past(sel)] == $past(tot_q[sel]))
        else $error("counter read disturbed bandwidth count");
    a_evict_dec: assert property (evict_valid && occ_inc[evict_tag] == '0 && // R18
        occ_q[evict_tag] != '0 |=> occ_q[$past(evict_tag)] ==
        $past(occ_q[evict_tag]) - CTR_W'(1))
        else $error("eviction did not lower occupancy");
    a_sel_follow: assert property (wr_ok && paddr == `RMC_OFS_EVTSEL && pstrb == 4'hF |=> // R7 R20
        evt_code_q == $past(pwdata[7:0]) && evt_tag_q == $past(pwdata[25:16]))
        else $error("event select not taken");

    c_ctr_read: cover property (ctr_read && !ctr_word.err && !ctr_word.unav);
    c_ovf_read: cover property (ctr_read && ctr_word.ovf);
    c_assoc_wr: cover property (wr_ok && mon_reg && paddr >= `RMC_OFS_ASSOC0);
    c_unmapped: cover property (done && pslverr);
endmodule

// File: testbench/rmc_top_bench.sv
// self-checking bench for the resource monitor: feature queries, tagging, counters and flags
`timescale 1ns/1ps
`include "rmc_map.svh"
module rmc_top_bench import rmc_pkg::*;;
    // query row: select word, register to read, expected word
    typedef struct packed {
        logic [31:0] qsel;
        logic [11:0] addr;
        logic [31:0] exp;
    } rmc_row_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rmc_traffic_t [3:0] traffic = '0;
    logic evict_valid = 1'b0;
    logic [3:0] evict_tag = 4'h0;
    logic monitor_hold = 1'b0;
    logic [3:0][3:0] thread_tag;
    logic [31:0] nm_prdata;
    logic nm_pslverr;
    logic [31:0] nm_rd = 32'h0000_0000;
    logic nm_er = 1'b0;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    rmc_row_t rows [7] = '{
        '{32'h0000_0007, `RMC_OFS_QEBX, 32'h0000_1000},
        '{32'h0000_000F, `RMC_OFS_QEBX, 32'h0000_000F},
        '{32'h0000_000F, `RMC_OFS_QEDX, 32'h0000_0002},
        '{32'h0000_010F, `RMC_OFS_QEBX, 32'h0000_E000},
        '{32'h0000_010F, `RMC_OFS_QECX, 32'h0000_0007},
        '{32'h0000_010F, `RMC_OFS_QEDX, 32'h0000_0007},
        '{32'h0000_0003, `RMC_OFS_QEBX, 32'h0000_0000}
    };

    // small counter width so a bandwidth wrap takes only sixteen pulses
    rmc_top #(.CTR_W(4)) i_rmc_top (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .thread_traffic(traffic),
        .evict_valid(evict_valid),
        .evict_tag(evict_tag),
        .monitor_hold(monitor_hold),
        .thread_tag(thread_tag)
    );

    // twin without monitoring support: same bus, monitor registers must refuse
    rmc_top #(.CTR_W(4), .MON_SUP(1'b0)) i_rmc_top_nomon (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(nm_prdata),
        .pready(),
        .pslverr(nm_pslverr),
        .thread_traffic(traffic),
        .evict_valid(evict_valid),
        .evict_tag(evict_tag),
        .monitor_hold(monitor_hold),
        .thread_tag()
    );

    always #2 pclk = ~pclk;

    // hang guard, well above the few hundred cycles the sequence needs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // one apb transfer; entered just after a rising edge, leaves one edge after pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no own limit: only the hang guard ends a wait for pready
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        nm_rd = nm_prdata;
        nm_er = nm_pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
        chk({31'd0, er}, 32'd0, "write error response");
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] v;
        logic er;
        apb(1'b0, a, 32'h0000_0000, v, er);
        chk(v, exp, "read data");
        chk({31'd0, er}, {31'd0, experr}, "read error response");
    endtask

    // select a tag and event code, then read the counter word
    task automatic ctr(input logic [9:0] tag, input logic [7:0] code, input logic [31:0] exp);
        wr(`RMC_OFS_EVTSEL, {6'd0, tag, 8'd0, code});
        rd(`RMC_OFS_COUNTER, exp, 1'b0);
    endtask

    task automatic pulse(input logic [3:0] thr, input logic [2:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            for (int t = 0; t < 4; t++) begin
                traffic[t] <= thr[t] ? rmc_traffic_t'(b) : rmc_traffic_t'(3'b000);
            end
            @(posedge pclk);
        end
        traffic <= '0;
        @(posedge pclk);
    endtask

    task automatic evict(input logic [3:0] t, input int n);
        evict_tag <= t;
        evict_valid <= 1'b1;
        repeat (n) @(posedge pclk);
        evict_valid <= 1'b0;
        @(posedge pclk);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // query table
        foreach (rows[i]) begin
            wr(`RMC_OFS_QSEL, rows[i].qsel);
            rd(rows[i].addr, rows[i].exp, 1'b0);
        end
        // support bit on both builds; queries never refused
        wr(`RMC_OFS_QSEL, 32'h0000_0007);
        rd(`RMC_OFS_QEBX, 32'h0000_1000, 1'b0);
        chk(nm_rd, 32'h0000_0000, "support bit on unsupported twin");
        chk({31'd0, nm_er}, 32'd0, "query refused on twin");
        // state left by reset
        chk(32'(thread_tag), 32'h0000_0000, "tags after reset");
        rd(`RMC_OFS_ASSOC0, 32'h0000_0000, 1'b0);
        rd(`RMC_OFS_COUNTER, 32'h8000_0000, 1'b0);
        chk({31'd0, nm_er}, 32'd1, "monitor access not refused");
        chk(nm_rd, 32'h0000_0000, "refused read data");
        rd(12'h100, 32'h0000_0000, 1'b1);
        // tag association, masked write lanes leave thread 2 alone
        wr(`RMC_OFS_ASSOC0 + 12'h004, 32'h0000_0001);
        pstrb <= 4'h0;
        wr(`RMC_OFS_ASSOC0 + 12'h008, 32'h0000_0005);
        pstrb <= 4'hF;
        chk(32'(thread_tag), 32'h0000_0010, "tags after assoc");
        // threads 0 and 1 carry total traffic, each to its own tag
        pulse(4'b0011, 3'b010, 3);
        ctr(10'd1, `RMC_EVT_TOT, 32'h0000_0003);
        ctr(10'd0, `RMC_EVT_TOT, 32'h0000_0003);
        ctr(10'd1, `RMC_EVT_TOT, 32'h0000_0003);
        ctr(10'd1, `RMC_EVT_LOC, 32'h0000_0000);
        // occupancy follows fills and evictions, floor at zero
        pulse(4'b0011, 3'b100, 2);
        evict(4'd1, 1);
        ctr(10'd1, `RMC_EVT_OCC, 32'h0000_0001);
        evict(4'd1, 2);
        ctr(10'd1, `RMC_EVT_OCC, 32'h0000_0000);
        // wrap of the four-bit total counter: 3 + 14 = 17 wraps to 1
        pulse(4'b0010, 3'b010, 14);
        ctr(10'd1, `RMC_EVT_TOT, 32'h2000_0001);
        rd(`RMC_OFS_COUNTER, 32'h0000_0001, 1'b0);
        // error and unavailable conditions, and their automatic clearing
        ctr(10'd16, `RMC_EVT_TOT, 32'h8000_0000);
        ctr(10'd1, 8'h04, 32'h8000_0000);
        ctr(10'd1, 8'h00, 32'h8000_0000);
        ctr(10'd8, `RMC_EVT_OCC, 32'h4000_0000);
        ctr(10'd15, `RMC_EVT_TOT, 32'h4000_0000);
        ctr(10'd7, `RMC_EVT_TOT, 32'h0000_0000);
        monitor_hold <= 1'b1;
        rd(`RMC_OFS_COUNTER, 32'h8000_0000, 1'b0);
        monitor_hold <= 1'b0;
        @(posedge pclk);
        rd(`RMC_OFS_COUNTER, 32'h0000_0000, 1'b0);
        ctr(10'd1, `RMC_EVT_TOT, 32'h0000_0001);
        // context switch: thread 1 moves to tag 2, the old tag keeps its count
        wr(`RMC_OFS_ASSOC0 + 12'h004, 32'h0000_0002);
        pulse(4'b0010, 3'b010, 2);
        ctr(10'd2, `RMC_EVT_TOT, 32'h0000_0002);
        ctr(10'd1, `RMC_EVT_TOT, 32'h0000_0001);
        // reset in mid-run clears tags and counters
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(thread_tag), 32'h0000_0000, "tags after second reset");
        ctr(10'd2, `RMC_EVT_TOT, 32'h0000_0000);
        end_sim();
    end
endmodule
